// ---- core/spbs_host.sv ----
/*
  Initiator agent on the secondary bus that makes one-word accesses to the
  bridge, returns each completed word through a two-entry buffer, and drives
  and observes the speed capability straps.
  Assumes the bus clock is clk, an arbiter supplies sec_gnt_n, and a board
  resolves each pin from its output enable.
*/
`timescale 1ns/1ns

module spbs_host import spbs_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [CBE_W-1:0] req_cmd,
  input wire logic [AD_W-1:0] req_addr,
  input wire logic [AD_W-1:0] req_data,
  input wire logic [CBE_W-1:0] req_be,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [AD_W-1:0] rsp_data,
  output logic xfer_done,
  output logic xfer_abort,
  output logic parity_error,
  input wire logic sec_gnt_n,
  output logic [AD_W-1:0] sec_ad_o,
  output logic sec_ad_oe,
  input wire logic [AD_W-1:0] sec_ad_i,
  output logic [CBE_W-1:0] sec_cmd_byte_enable_lanes_o,
  output logic sec_cmd_byte_enable_lanes_oe,
  input wire logic [CBE_W-1:0] sec_cmd_byte_enable_lanes_i,
  output logic sec_parity_line_o,
  output logic sec_parity_line_oe,
  input wire logic sec_parity_line_i,
  output logic sec_frame_n_o,
  output logic sec_frame_n_oe,
  input wire logic sec_frame_n_i,
  output logic sec_initiator_ready_n_o,
  output logic sec_initiator_ready_n_oe,
  input wire logic sec_initiator_ready_n_i,
  input wire logic sec_target_ready_n_i,
  input wire logic speed_66_sel,
  output logic primary_speed_capable_in,
  input wire logic secondary_speed_capable_pin_i,
  output logic sec_speed_66
);

  spbs_regs_s s_r;
  spbs_regs_s s_nxt;
  logic xfer;
  logic push;
  logic pop;

  always_comb begin
    s_nxt = s_r;
    xfer = 1'b0;
    push = 1'b0;
    pop = s_r.vld && rsp_ready;
    s_nxt.done = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.chk = 1'b0;
    // Parity covers what was driven one cycle earlier and follows its enable.
    s_nxt.par = ^{s_r.ad, s_r.cbe};
    s_nxt.par_oe = s_r.ad_oe;
    s_nxt.perr = s_r.chk && (s_r.exp != sec_parity_line_i);
    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.rdy && req_valid) begin
          s_nxt.st = ST_ADDR;
          s_nxt.frame_n = 1'b0;
          s_nxt.frame_oe = 1'b1;
          s_nxt.ad = req_addr;
          s_nxt.ad_oe = 1'b1;
          s_nxt.cbe = req_cmd;
          s_nxt.cbe_oe = 1'b1;
          s_nxt.wr = req_write;
          s_nxt.wdat = req_data;
          s_nxt.be = req_be;
          s_nxt.tmo = 4'h0;
        end
      end
      ST_ADDR: begin
        s_nxt.st = ST_DATA;
        s_nxt.frame_n = 1'b1;
        s_nxt.cbe = s_r.be;
        s_nxt.irdy_oe = 1'b1;
        s_nxt.irdy_n = (s_r.cnt == BUF_FULL);
        s_nxt.ad = s_r.wr ? s_r.wdat : s_r.ad;
        s_nxt.ad_oe = s_r.wr;
      end
      ST_DATA: begin
        xfer = !s_r.irdy_n && !sec_target_ready_n_i;
        if (s_r.irdy_n) begin
          s_nxt.irdy_n = (s_r.cnt == BUF_FULL);
        end else begin
          s_nxt.tmo = s_r.tmo + 4'h1;
        end
        if (xfer || (!s_r.irdy_n && s_r.tmo == ABORT_CYCLES)) begin
          s_nxt.st = ST_TURN;
          s_nxt.frame_oe = 1'b0;
          s_nxt.irdy_n = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.cbe_oe = 1'b0;
          s_nxt.done = xfer;
          s_nxt.abort = !xfer;
          push = xfer;
          s_nxt.chk = xfer && !s_r.wr;
          s_nxt.exp = ^{sec_ad_i, sec_cmd_byte_enable_lanes_i};
        end
      end
      ST_TURN: begin
        s_nxt.st = ST_IDLE;
        s_nxt.irdy_oe = 1'b0;
      end
    endcase
    if (pop) begin
      s_nxt.rp = !s_r.rp;
    end
    if (push) begin
      s_nxt.mem[s_r.wp] = s_r.wr ? s_r.wdat : sec_ad_i;
      s_nxt.wp = !s_r.wp;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    s_nxt.vld = (s_nxt.cnt != 2'h0);
    s_nxt.rdat = s_nxt.mem[s_nxt.rp];
    // Start only on an idle bus with our grant, so a parked bridge is never fought.
    s_nxt.rdy = (s_nxt.st == ST_IDLE) && !sec_gnt_n && sec_frame_n_i
      && sec_initiator_ready_n_i && !(s_r.rdy && req_valid);
    s_nxt.p66 = speed_66_sel;
    s_nxt.sy0 = secondary_speed_capable_pin_i;
    s_nxt.sy1 = s_r.sy0;
    s_nxt.s66 = s_r.sy1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.frame_n <= FRAME_N_RST;
      s_r.irdy_n <= IRDY_N_RST;
      s_r.p66 <= SPEED_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready = s_r.rdy;
  assign rsp_valid = s_r.vld;
  assign rsp_data = s_r.rdat;
  assign xfer_done = s_r.done;
  assign xfer_abort = s_r.abort;
  assign parity_error = s_r.perr;
  assign sec_ad_o = s_r.ad;
  assign sec_ad_oe = s_r.ad_oe;
  assign sec_cmd_byte_enable_lanes_o = s_r.cbe;
  assign sec_cmd_byte_enable_lanes_oe = s_r.cbe_oe;
  assign sec_parity_line_o = s_r.par;
  assign sec_parity_line_oe = s_r.par_oe;
  assign sec_frame_n_o = s_r.frame_n;
  assign sec_frame_n_oe = s_r.frame_oe;
  assign sec_initiator_ready_n_o = s_r.irdy_n;
  assign sec_initiator_ready_n_oe = s_r.irdy_oe;
  assign primary_speed_capable_in = s_r.p66;
  assign sec_speed_66 = s_r.s66;

  logic par_ref_q;

  always_ff @(posedge clk) begin
    par_ref_q <= ^{sec_ad_o, sec_cmd_byte_enable_lanes_o};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_addr;
    sec_frame_n_oe && !sec_frame_n_o && sec_ad_oe;
  endsequence

  sequence seq_data;
    sec_frame_n_oe && sec_frame_n_o && sec_initiator_ready_n_oe;
  endsequence

  addr_then_data_a: assert property (seq_addr |=> seq_data)
    else $error("Address phase not followed by final data phase.");
  frame_release_a: assert property ($fell(sec_frame_n_oe) |-> $past(sec_frame_n_o))
    else $error("Frame released while still asserted.");
  irdy_release_a: assert property ($fell(sec_initiator_ready_n_oe)
    |-> $past(sec_initiator_ready_n_o))
    else $error("Initiator ready released while asserted.");
  irdy_hold_a: assert property (sec_initiator_ready_n_oe && !sec_initiator_ready_n_o
    && sec_target_ready_n_i && !xfer_abort |=> !sec_initiator_ready_n_o
    || xfer_abort)
    else $error("Initiator ready dropped before the phase ended.");
  par_release_a: assert property ($fell(sec_ad_oe) |-> sec_parity_line_oe
    ##1 !sec_parity_line_oe)
    else $error("Parity not released one cycle after the data lines.");
  par_even_a: assert property (sec_parity_line_oe |-> sec_parity_line_o == par_ref_q)
    else $error("Driven parity is not even.");
  addr_par_a: assert property (seq_addr |=> sec_parity_line_oe)
    else $error("Address parity missing after address phase.");
  cmd_lanes_a: assert property (req_valid && req_ready |=> seq_addr
    ##0 sec_cmd_byte_enable_lanes_o == $past(req_cmd))
    else $error("Command code not on lanes in address phase.");
  wr_par_a: assert property (sec_ad_oe && !sec_initiator_ready_n_o
    && sec_initiator_ready_n_oe |=> sec_parity_line_oe)
    else $error("Write parity not driven after initiator ready.");
  done_xfer_a: assert property (xfer_done |-> $past(!sec_target_ready_n_i)
    && $past(!sec_initiator_ready_n_o))
    else $error("Completion without both ready signals.");
  park_quiet_a: assert property (sec_gnt_n && !sec_frame_n_oe |-> !sec_ad_oe
    || sec_parity_line_oe)
    else $error("Data lines driven without an own access.");

  sequence seq_take;
    req_valid && req_ready;
  endsequence

  sequence seq_turn;
    !sec_frame_n_oe && sec_initiator_ready_n_oe && sec_initiator_ready_n_o;
  endsequence

  grant_start_a: assert property ($rose(sec_frame_n_oe) |-> !$past(sec_gnt_n, 2))
    else $error("Access started without the bus grant.");

  frame_open_a: assert property ($rose(sec_frame_n_oe) |-> !sec_frame_n_o)
    else $error("Frame driven without opening the access.");

  frame_single_a: assert property (sec_frame_n_oe && !sec_frame_n_o |=> sec_frame_n_o)
    else $error("Frame held past the single data phase.");

  frame_idle_a: assert property (!sec_frame_n_oe |-> sec_frame_n_o)
    else $error("Released frame does not hold the deasserted level.");

  irdy_idle_a: assert property (!sec_initiator_ready_n_oe |-> sec_initiator_ready_n_o)
    else $error("Released initiator ready does not hold the deasserted level.");

  irdy_turn_a: assert property ($fell(sec_frame_n_oe) |-> seq_turn
    ##1 !sec_initiator_ready_n_oe)
    else $error("Initiator ready not parked high for one cycle before release.");

  cbe_release_a: assert property ($fell(sec_frame_n_oe) |-> !sec_cmd_byte_enable_lanes_oe)
    else $error("Command lanes still driven after the data phase.");

  be_lanes_a: assert property (seq_take |-> ##2 sec_cmd_byte_enable_lanes_oe
    && sec_cmd_byte_enable_lanes_o == $past(req_be, 2))
    else $error("Byte enables not on lanes in the data phase.");

  addr_lanes_a: assert property (seq_take |=> sec_ad_oe
    && sec_ad_o == $past(req_addr))
    else $error("Address not driven in the address phase.");

  wdata_lanes_a: assert property (seq_take ##0 req_write |-> ##2 sec_ad_oe
    && sec_ad_o == $past(req_data, 2))
    else $error("Write data not driven in the data phase.");

  rdata_turn_a: assert property (seq_take ##0 !req_write |-> ##2 !sec_ad_oe)
    else $error("Data lines not released for read data.");

  done_pulse_a: assert property (xfer_done |=> !xfer_done)
    else $error("Completion pulse longer than one cycle.");

  abort_wait_a: assert property (xfer_abort |-> $past(sec_target_ready_n_i))
    else $error("Abort although target ready was seen.");

  perr_read_a: assert property (parity_error |-> !$past(sec_parity_line_oe))
    else $error("Parity error flagged on parity this side drove.");

  busy_ready_a: assert property (sec_frame_n_oe |-> !req_ready)
    else $error("Request port ready during an access.");

  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid
    && $stable(rsp_data))
    else $error("Buffered word changed before it was taken.");

  speed_pri_a: assert property (primary_speed_capable_in == $past(speed_66_sel))
    else $error("Primary speed strap does not follow its select.");

  speed_sec_a: assert property (sec_speed_66 == $past(secondary_speed_capable_pin_i, 3))
    else $error("Secondary speed flag does not follow its synchronised pin.");

endmodule

// ---- core/spbs_pkg.sv ----
/*
  Shared constants and state types for the secondary bus initiator.
  Assumes one 100 MHz clock that is also the secondary bus clock.
*/
package spbs_pkg;

  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [3:0] ABORT_CYCLES = 4'hF;
  localparam logic FRAME_N_RST = 1'b1;
  localparam logic IRDY_N_RST = 1'b1;
  localparam logic SPEED_RST = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_TURN = 2'b11
  } spbs_state_e;

  typedef struct packed {
    spbs_state_e st;
    logic rdy;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic [AD_W-1:0] ad;
    logic ad_oe;
    logic [CBE_W-1:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic wr;
    logic [AD_W-1:0] wdat;
    logic [CBE_W-1:0] be;
    logic [3:0] tmo;
    logic chk;
    logic exp;
    logic perr;
    logic abort;
    logic done;
    logic [BUF_DEPTH-1:0][AD_W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic vld;
    logic [AD_W-1:0] rdat;
    logic sy0;
    logic sy1;
    logic s66;
    logic p66;
  } spbs_regs_s;

endpackage

// ---- test/spbs_bridge_model.sv ----
/*
  Bridge model on the secondary bus: target side, straps and status bit.
  Assumes the host holds the grant and released lines are resolved here.
*/
`timescale 1ns/1ns
module spbs_bridge_model import spbs_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic [AD_W-1:0] sec_ad_o,
  input wire logic sec_ad_oe,
  output logic [AD_W-1:0] sec_ad_i,
  input wire logic [CBE_W-1:0] sec_cmd_byte_enable_lanes_o,
  input wire logic sec_cmd_byte_enable_lanes_oe,
  output logic [CBE_W-1:0] sec_cmd_byte_enable_lanes_i,
  input wire logic sec_parity_line_o,
  input wire logic sec_parity_line_oe,
  output logic sec_parity_line_i,
  input wire logic sec_frame_n_o,
  input wire logic sec_frame_n_oe,
  output logic sec_frame_n_i,
  input wire logic sec_initiator_ready_n_o,
  input wire logic sec_initiator_ready_n_oe,
  output logic sec_initiator_ready_n_i,
  output logic sec_target_ready_n_i,
  input wire logic primary_speed_capable_in,
  output logic secondary_speed_capable_pin_i,
  input wire logic async_mode,
  input wire logic speed_config_option,
  output logic status_66,
  input wire logic [4:0] trdy_delay,
  input wire logic bad_par,
  input wire logic [AD_W-1:0] rd_word,
  output logic [AD_W-1:0] seen_addr,
  output logic [AD_W-1:0] seen_wdata,
  output logic [7:0] seen_cbe,
  output logic [7:0] par_errs
);
  logic [AD_W-1:0] lad;
  logic [CBE_W-1:0] lcbe;
  logic [36:0] prv;
  logic lpar, pvo, act, tm, wr, pm, pmo;
  logic [4:0] wt;
  wire dro = act & tm & ~wr;
  assign sec_ad_i = sec_ad_oe ? sec_ad_o : dro ? rd_word : ~lad;
  assign sec_cmd_byte_enable_lanes_i = sec_cmd_byte_enable_lanes_oe ?
    sec_cmd_byte_enable_lanes_o : ~lcbe;
  assign sec_parity_line_i = sec_parity_line_oe ? sec_parity_line_o : pmo ? pm : ~lpar;
  assign sec_frame_n_i = sec_frame_n_oe ? sec_frame_n_o : 1'b1;
  assign sec_initiator_ready_n_i = sec_initiator_ready_n_oe ? sec_initiator_ready_n_o : 1'b1;
  assign sec_target_ready_n_i = ~tm;
  assign secondary_speed_capable_pin_i = async_mode | primary_speed_capable_in;
  assign status_66 = async_mode ? primary_speed_capable_in : speed_config_option;
  always_ff @(posedge clk) begin
    lad <= sec_ad_i;
    lcbe <= sec_cmd_byte_enable_lanes_i;
    lpar <= sec_parity_line_i;
    prv <= {sec_ad_i, sec_cmd_byte_enable_lanes_i, 1'b0};
    pvo <= sec_ad_oe;
    pmo <= dro;
    pm <= ^{rd_word, sec_cmd_byte_enable_lanes_i, bad_par};
    if (reset) begin
      act <= 1'b0;
      tm <= 1'b0;
      par_errs <= 8'h00;
    end else begin
      if (pvo && sec_parity_line_oe && ^{prv, sec_parity_line_o}) begin
        par_errs <= par_errs + 8'h01;
      end
      if (!act && !sec_frame_n_i && sec_ad_oe) begin
        act <= 1'b1;
        wr <= sec_cmd_byte_enable_lanes_o[0];
        seen_addr <= sec_ad_o;
        seen_cbe[7:4] <= sec_cmd_byte_enable_lanes_o;
        wt <= trdy_delay;
        tm <= trdy_delay == 5'h00;
      end else if (act && tm && !sec_initiator_ready_n_i) begin
        act <= 1'b0;
        tm <= 1'b0;
        seen_cbe[3:0] <= sec_cmd_byte_enable_lanes_i;
        seen_wdata <= wr ? sec_ad_i : seen_wdata;
      end else if (act && !sec_frame_n_oe && !sec_initiator_ready_n_oe) begin
        act <= 1'b0;
        tm <= 1'b0;
      end else if (act && !tm) begin
        wt <= wt - 5'h01;
        tm <= wt <= 5'h01;
      end
    end
  end
endmodule

// ---- test/testbench.sv ----
/*
  Testbench for the secondary bus initiator.
  Assumes the bridge model stands on the far side of the pins.
*/
`timescale 1ns/1ns
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module testbench import spbs_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, rsp_ready = 1'b0;
  logic sec_gnt_n = 1'b0, speed_66_sel = 1'b0, async_mode = 1'b0, speed_config_option = 1'b0;
  logic bad_par = 1'b0, dn, ab, pe;
  logic [4:0] trdy_delay = 5'h00;
  logic [CBE_W-1:0] req_cmd = 4'h0, req_be = 4'h0;
  logic [CBE_W-1:0] sec_cmd_byte_enable_lanes_o, sec_cmd_byte_enable_lanes_i;
  logic [AD_W-1:0] req_addr = 32'h0, req_data = 32'h0, rd_word = 32'h0;
  logic [AD_W-1:0] rsp_data, sec_ad_o, sec_ad_i, seen_addr, seen_wdata;
  logic [7:0] seen_cbe, par_errs;
  logic req_ready, rsp_valid, xfer_done, xfer_abort, parity_error, sec_ad_oe, status_66;
  logic sec_cmd_byte_enable_lanes_oe, sec_parity_line_o, sec_parity_line_oe, sec_parity_line_i;
  logic sec_frame_n_o, sec_frame_n_oe, sec_frame_n_i, sec_initiator_ready_n_o;
  logic sec_initiator_ready_n_oe, sec_initiator_ready_n_i, sec_target_ready_n_i;
  logic primary_speed_capable_in, secondary_speed_capable_pin_i, sec_speed_66;
  int fails = 0, comparisons = 0;
  spbs_host uut (.*);
  spbs_bridge_model bridge (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic go(input logic w, input logic [31:0] a, d, input logic [3:0] be);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_cmd <= {3'h3, w};
    req_addr <= a;
    req_data <= d;
    req_be <= be;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask
  task automatic wt_end(input int lim);
    dn = 1'b0;
    ab = 1'b0;
    pe = 1'b0;
    for (int n = 0; n < lim && !dn && !ab; n++) begin
      @(posedge clk);
      dn = xfer_done === 1'b1;
      ab = xfer_abort === 1'b1;
    end
    repeat (2) begin
      @(posedge clk);
      pe = pe | (parity_error === 1'b1);
    end
  endtask
  task automatic pop(input logic [31:0] e);
    @(posedge clk);
    for (int n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(posedge clk);
    `CK("rsp_data", e, rsp_data)
    rsp_ready <= 1'b1;
    @(posedge clk);
    rsp_ready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, w, input logic [3:0] be);
    rd_word <= w;
    go(1'b0, a, 32'h0, be);
    wt_end(60);
    `CK("done", 1'b1, dn)
    `CK("cbe", {4'h6, be}, seen_cbe)
    `CK("addr", a, seen_addr)
  endtask
  task automatic t_rd_wr;
    rd(32'h1000_0040, 32'hA5C3_0F01, 4'h3);
    `CK("perr", 1'b0, pe)
    pop(32'hA5C3_0F01);
    go(1'b1, 32'h2000_0008, 32'h8001_7FFE, 4'hC);
    wt_end(60);
    `CK("wdata", 32'h8001_7FFE, seen_wdata)
    `CK("wcbe", 8'h7C, seen_cbe)
    `CK("par_errs", 8'h00, par_errs)
    pop(32'h8001_7FFE);
    bad_par <= 1'b1;
    rd(32'h0000_0FFC, 32'h0000_0001, 4'hF);
    `CK("bad perr", 1'b1, pe)
    pop(32'h0000_0001);
    bad_par <= 1'b0;
    $display("t_rd_wr over");
  endtask
  task automatic t_abort;
    trdy_delay <= 5'h1F;
    go(1'b0, 32'h3000_0000, 32'h0, 4'hF);
    wt_end(60);
    `CK("abort", 1'b1, ab)
    `CK("no push", 1'b0, rsp_valid)
    $display("t_abort over");
  endtask
  task automatic t_full;
    trdy_delay <= 5'h02;
    rd(32'h10, 32'h1111_0000, 4'h1);
    rd(32'h20, 32'h2222_0000, 4'h2);
    rd_word <= 32'h3333_0000;
    go(1'b0, 32'h30, 32'h0, 4'h4);
    wt_end(20);
    `CK("stall", 1'b0, dn)
    pop(32'h1111_0000);
    wt_end(60);
    `CK("resume", 1'b1, dn)
    pop(32'h2222_0000);
    pop(32'h3333_0000);
    $display("t_full over");
  endtask
  task automatic t_grant;
    sec_gnt_n <= 1'b1;
    repeat (2) @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_cmd <= 4'h7;
    req_addr <= 32'h4000_0004;
    req_data <= 32'h0F0F_F0F0;
    req_be <= 4'hF;
    repeat (8) @(posedge clk);
    `CK("no grant ready", 1'b0, req_ready)
    `CK("no grant frame", 1'b0, sec_frame_n_oe)
    sec_gnt_n <= 1'b0;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    wt_end(60);
    `CK("grant done", 1'b1, dn)
    `CK("grant wdata", 32'h0F0F_F0F0, seen_wdata)
    pop(32'h0F0F_F0F0);
    $display("t_grant over");
  endtask
  task automatic t_speed;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      async_mode <= m[1];
      speed_66_sel <= m[0];
      speed_config_option <= ~m[0];
      repeat (6) @(posedge clk);
      `CK("pri", m[0], primary_speed_capable_in)
      `CK("stat", m[1] ? m[0] : ~m[0], status_66)
      `CK("sec", m[1] | m[0], sec_speed_66)
    end
    $display("t_speed over");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_rd_wr();
    t_abort();
    t_full();
    t_grant();
    t_speed();
    finish_test();
  end
endmodule
